// file: hw/sl_ctrl_status.sv
// Purpose: Control, match and status core of a synchronous serial line controller.
// Assumes: Modem clocks and pins are asynchronous and pass a three stage filter.
// Notes: Characters are eight bits, least significant bit first on the line.
`timescale 1ns/1ps
module sl_ctrl_status import sl_pkg::*; #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Host command port and status
  input  wire logic               cmd_valid,
  input  wire sl_cmd_req_t        cmd,
  input  wire sl_fmt_t            fmt,
  input  wire logic               io_program_active,
  input  wire logic               read_order_active,
  output sl_status_t              status_word,
  output logic                    irq,
  output logic                    device_end,
  output logic                    jump_cond,
  // Received words to the channel
  output logic                    service_request,
  input  wire logic               rd_ready,
  output logic [WORD_W-1:0]       rd_data,
  // Words to transmit from the channel
  input  wire logic               wr_valid,
  output logic                    wr_ready,
  input  wire logic [WORD_W-1:0]  wr_data,
  // Modem pins
  input  wire logic               rx_clk,
  input  wire logic               tx_clk,
  input  wire logic               rx_data,
  input  wire logic [MSTAT_W-1:0] modem_status_inputs,
  output logic                    tx_data,
  output logic [3:0]              modem_ctl
);

  initial begin
    if (BUF_DEPTH < 2) $error("sl_ctrl_status: BUF_DEPTH below two");
  end

  typedef struct packed {
    logic [PIN_W-1:0]        meta1;
    logic [PIN_W-1:0]        meta2;
    logic [PIN_W-1:0]        meta3;
    logic [PIN_W-1:0]        pin;
    sl_line_t                lc;
    logic [SLOTS-1:0][15:0]  slot;
    logic                    int_en;
    logic                    mask;
    logic [SRC_W-1:0]        int_src;
    logic                    irq;
    logic                    jump;
    logic                    dev_end;
    sl_rx_st_t               rx_st;
    logic [CHAR_W-1:0]       rx_sh;
    logic [3:0]              rx_cnt;
    logic                    half;
    logic [CHAR_W-1:0]       hi;
    logic                    push_valid;
    logic [WORD_W-1:0]       push_word;
    logic                    perr;
    logic                    xfer;
    logic                    brk;
    logic                    assoc;
    sl_tx_st_t               tx_st;
    logic [CHAR_W-1:0]       tx_sh;
    logic [3:0]              tx_cnt;
    logic [WORD_W-1:0]       tx_word;
    logic                    tx_full;
    logic                    tx_second;
    logic                    tx_line;
    logic                    txd;
    sl_status_t              st;
  } sl_state_t;

  sl_state_t           s_r;
  sl_state_t           s_nxt;
  logic [PIN_W-1:0]    pins_in;
  logic [PIN_W-1:0]    agree;
  logic                rx_go;
  logic                tx_go;
  logic [CHAR_W-1:0]   rx_shift;
  logic [CHAR_W-1:0]   cmp_char;
  logic [SLOTS-1:0]    hit;
  logic [SLOTS-1:0]    f_jump;
  logic [SLOTS-1:0]    f_dev;
  logic [SLOTS-1:0]    f_int;
  logic [SLOTS-1:0]    f_nosr;
  logic [MIRQ_W-1:0]   stat_evt;
  logic                push_ready;
  logic                buf_flush;

  assign pins_in  = {rx_clk, tx_clk, rx_data, modem_status_inputs};
  // A pin counts as changed only once the second and third stages agree.
  assign agree    = ~(s_r.meta2 ^ s_r.meta3);
  assign rx_go    = agree[PIN_RXC] & s_r.meta2[PIN_RXC] & ~s_r.pin[PIN_RXC]
                    & ~s_r.lc.blind;
  assign tx_go    = agree[PIN_TXC] & ~s_r.meta2[PIN_TXC] & s_r.pin[PIN_TXC];
  assign rx_shift = {s_r.pin[PIN_RXD], s_r.rx_sh[CHAR_W-1:1]};
  assign cmp_char = (s_r.rx_st == RX_STOP) ? s_r.rx_sh : rx_shift;

  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_slot
      sl_match_t m;
      assign m          = s_r.slot[gi];
      assign hit[gi]    = (m.chr == cmp_char);
      assign f_jump[gi] = m.jump;
      assign f_dev[gi]  = m.dev_end;
      assign f_int[gi]  = m.intr;
      assign f_nosr[gi] = m.no_sr;
    end
    for (gi = 0; gi < MIRQ_W; gi++) begin : g_mstat
      // Input i is status line Si; enable bit 8 + i sits at field bit 3 - i.
      assign stat_evt[gi] = agree[gi] & (s_r.meta2[gi] ^ s_r.pin[gi])
                            & s_r.lc.st_ie[MIRQ_W-1-gi];
    end
  endgenerate

  always_comb begin
    logic [SRC_W-1:0] evt;
    logic             int_clr;
    logic             jump_set;
    logic             jump_clr;
    logic             clr_rx;
    logic             io_rst;
    logic             ch_done;
    logic             last;
    sl_rx_st_t        rx_idle;
    sl_intc_t         ic;
    evt      = '0;
    int_clr  = 1'b0;
    jump_set = 1'b0;
    jump_clr = 1'b0;
    clr_rx   = 1'b0;
    io_rst   = 1'b0;
    ch_done  = 1'b0;
    last     = 1'b0;
    rx_idle  = fmt.async_mode ? RX_WAIT : RX_HUNT;
    ic       = cmd.data;
    s_nxt    = s_r;
    s_nxt.meta1   = pins_in;
    s_nxt.meta2   = s_r.meta1;
    s_nxt.meta3   = s_r.meta2;
    s_nxt.pin     = (s_r.pin & ~agree) | (s_r.meta2 & agree);
    s_nxt.dev_end = 1'b0;
    s_nxt.push_valid = s_r.push_valid & ~push_ready;
    evt[SRC_STAT] = |stat_evt;

    if (cmd_valid) begin
      case (cmd.sel)
        CMD_LINE:     s_nxt.lc = cmd.data;
        CMD_MATCH:    s_nxt.slot[cmd.data[SLOT_HI:SLOT_LO]] = cmd.data;
        CMD_INTC: begin
          s_nxt.int_en = ic.en;
          int_clr      = ic.clr;
        end
        CMD_CLR_RX:   clr_rx = 1'b1;
        CMD_IO_RESET: io_rst = 1'b1;
        CMD_SET_MASK: s_nxt.mask = 1'b1;
        CMD_CLR_MASK: s_nxt.mask = 1'b0;
        CMD_SET_INT:  evt[SRC_SET] = 1'b1;
        CMD_JUMP:     jump_clr = 1'b1;
        CMD_XFER_ERR: begin
          s_nxt.xfer     = 1'b1;
          evt[SRC_XFER]  = 1'b1;
        end
        default: ;
      endcase
    end
    if (io_rst) begin
      s_nxt.lc        = '0;
      s_nxt.slot      = '0;
      s_nxt.int_en    = 1'b0;
      s_nxt.mask      = 1'b1;
      s_nxt.xfer      = 1'b0;
      s_nxt.tx_st     = TX_IDLE;
      s_nxt.tx_full   = 1'b0;
      s_nxt.tx_line   = TX_MARK;
      jump_clr        = 1'b1;
      clr_rx          = 1'b1;
    end
    if (clr_rx) begin
      // Receive clear drops everything queued and re-enters hunt, or the start-bit wait in async mode.
      s_nxt.rx_st      = rx_idle;
      s_nxt.rx_cnt     = '0;
      s_nxt.half       = 1'b0;
      s_nxt.perr       = 1'b0;
      s_nxt.brk        = 1'b0;
      s_nxt.assoc      = 1'b0;
      s_nxt.push_valid = 1'b0;
      int_clr          = 1'b1;
    end

    if (rx_go) begin
      case (s_r.rx_st)
        RX_HUNT: begin
          s_nxt.rx_sh = rx_shift;
          if (|(hit & f_nosr)) begin
            // The sync character still fires its jump, end and interrupt functions.
            ch_done      = 1'b1;
            s_nxt.rx_st  = RX_DATA;
            s_nxt.rx_cnt = '0;
            s_nxt.assoc  = 1'b1;
          end
        end
        RX_WAIT: begin
          if (!s_r.pin[PIN_RXD]) begin
            s_nxt.rx_st  = RX_DATA;
            s_nxt.rx_cnt = '0;
          end
        end
        RX_DATA: begin
          s_nxt.rx_sh  = rx_shift;
          s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          if (s_r.rx_cnt == BIT_LAST) begin
            s_nxt.rx_cnt = '0;
            if (fmt.async_mode) begin
              s_nxt.rx_st = RX_STOP;
            end else begin
              ch_done = 1'b1;
            end
          end
        end
        RX_STOP: begin
          s_nxt.rx_st = RX_WAIT;
          ch_done     = 1'b1;
          if (!s_r.pin[PIN_RXD]) begin
            s_nxt.brk     = 1'b1;
            evt[SRC_BRK]  = 1'b1;
          end
        end
        default: s_nxt.rx_st = rx_idle;
      endcase
    end

    if (ch_done) begin
      if (|hit) begin
        s_nxt.assoc = 1'b1;
      end
      if (read_order_active) begin
        jump_set        = |(hit & f_jump);
        s_nxt.dev_end   = |(hit & f_dev);
        evt[SRC_MTCH]   = |(hit & f_int);
      end
      if (fmt.par_en && ((^cmp_char) != fmt.par_odd)) begin
        s_nxt.perr     = 1'b1;
        evt[SRC_PERR]  = 1'b1;
      end
      if (!(|(hit & f_nosr))) begin
        if (fmt.rx_pack && !s_r.half) begin
          s_nxt.half = 1'b1;
          s_nxt.hi   = cmp_char;
        end else begin
          s_nxt.half = 1'b0;
          if (s_r.push_valid && !push_ready) begin
            s_nxt.perr    = 1'b1;
            evt[SRC_OVR]  = 1'b1;
          end else begin
            s_nxt.push_valid = 1'b1;
            s_nxt.push_word  = fmt.rx_pack ? {s_r.hi, cmp_char}
                                           : {ZERO_BYTE, cmp_char};
            evt[SRC_RX]      = s_r.lc.rx_ie;
          end
        end
      end
    end

    if (wr_valid && !s_r.tx_full) begin
      s_nxt.tx_full   = 1'b1;
      s_nxt.tx_word   = wr_data;
      s_nxt.tx_second = 1'b0;
    end
    if (tx_go) begin
      case (s_r.tx_st)
        TX_IDLE: begin
          s_nxt.tx_line = TX_MARK;
          if (s_r.tx_full) begin
            last = !fmt.tx_unpack || s_r.tx_second;
            s_nxt.tx_sh = (fmt.tx_unpack && !s_r.tx_second)
                          ? s_r.tx_word[WORD_W-1:CHAR_W]
                          : s_r.tx_word[CHAR_W-1:0];
            s_nxt.tx_second = !last;
            s_nxt.tx_cnt    = '0;
            s_nxt.tx_st     = fmt.async_mode ? TX_START : TX_DATA;
            if (last) begin
              s_nxt.tx_full = 1'b0;
              evt[SRC_TX]   = s_r.lc.tx_ie;
            end
          end
        end
        TX_START: begin
          s_nxt.tx_line = 1'b0;
          s_nxt.tx_st   = TX_DATA;
        end
        TX_DATA: begin
          s_nxt.tx_line = s_r.tx_sh[0];
          s_nxt.tx_sh   = s_r.tx_sh >> 1;
          s_nxt.tx_cnt  = s_r.tx_cnt + 4'h1;
          if (s_r.tx_cnt == BIT_LAST) begin
            s_nxt.tx_st = fmt.async_mode ? TX_STOP : TX_IDLE;
          end
        end
        TX_STOP: begin
          s_nxt.tx_line = TX_MARK;
          s_nxt.tx_st   = TX_IDLE;
        end
        default: s_nxt.tx_st = TX_IDLE;
      endcase
    end
    // The shifter keeps timing characters; only the pin is forced to mark.
    s_nxt.txd = s_nxt.lc.tx_dis ? TX_MARK : s_nxt.tx_line;

    // New events win over a clear in the same cycle.
    s_nxt.jump    = (jump_clr ? 1'b0 : s_r.jump) | jump_set;
    s_nxt.int_src = (int_clr ? '0 : s_r.int_src) | evt;
    s_nxt.irq     = (|s_nxt.int_src) & s_nxt.mask & s_nxt.int_en;

    s_nxt.st.prog_ok  = !io_program_active;
    s_nxt.st.read_ok  = service_request & !clr_rx;
    s_nxt.st.write_ok = !s_nxt.tx_full;
    s_nxt.st.rw_ok    = s_nxt.st.read_ok | s_nxt.st.write_ok;
    s_nxt.st.int_pend = |s_nxt.int_src;
    s_nxt.st.byte_f   = !fmt.rx_pack || s_nxt.half;
    s_nxt.st.perr_ovr = s_nxt.perr;
    s_nxt.st.xfer_err = s_nxt.xfer;
    s_nxt.st.brk      = fmt.async_mode & s_nxt.brk;
    s_nxt.st.assoc    = s_nxt.assoc;
    s_nxt.st.mstat    = {<<{s_nxt.pin[MSTAT_W-1:0]}};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.mask    <= 1'b1;
      s_r.rx_st   <= RX_HUNT;
      s_r.tx_st   <= TX_IDLE;
      s_r.tx_line <= TX_MARK;
      s_r.txd     <= TX_MARK;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign buf_flush = cmd_valid & ((cmd.sel == CMD_CLR_RX) | (cmd.sel == CMD_IO_RESET));

  sl_fifo2 #(
    .W     (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .flush     (buf_flush),
    .in_valid  (s_r.push_valid),
    .in_ready  (push_ready),
    .in_data   (s_r.push_word),
    .out_valid (service_request),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign status_word = s_r.st;
  assign irq         = s_r.irq;
  assign device_end  = s_r.dev_end;
  assign jump_cond   = s_r.jump;
  assign wr_ready    = ~s_r.tx_full;
  assign tx_data     = s_r.txd;
  assign modem_ctl   = s_r.lc.ctl_out;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence set_int_seq;
    cmd_valid && cmd.sel == CMD_SET_INT;
  endsequence
  sequence jump_clr_seq;
    cmd_valid && cmd.sel == CMD_JUMP && !s_nxt.dev_end && !rx_go;
  endsequence

  irq_gate_a: assert property (irq |-> s_r.mask && s_r.int_en)
    else $error("irq without mask and enable");
  tx_mark_a: assert property (s_r.lc.tx_dis |-> tx_data == TX_MARK)
    else $error("line not at mark while transmit disabled");
  ctl_out_a: assert property (cmd_valid && cmd.sel == CMD_LINE |=> modem_ctl == $past(cmd.data[3:0]))
    else $error("modem control not taken from line word");
  byte_flag_a: assert property (!fmt.rx_pack |=> status_word.byte_f)
    else $error("byte flag low in unpacked mode");
  brk_sync_a: assert property (!fmt.async_mode |=> !status_word.brk)
    else $error("break seen in synchronous mode");
  dev_end_a: assert property (device_end |-> $past(read_order_active))
    else $error("device end outside a read");
  jump_clr_a: assert property (jump_clr_seq |=> !jump_cond)
    else $error("jump flag not cleared by jump order");
  int_set_a: assert property (set_int_seq |=> status_word.int_pend ##0 (irq == (s_r.mask && s_r.int_en)))
    else $error("set interrupt not stored or delivered");
  blind_a: assert property (s_r.lc.blind && !cmd_valid |=> $stable(s_r.rx_sh) && !device_end)
    else $error("receive moved while blind");

endmodule // sl_ctrl_status

// file: hw/sl_fifo2.sv
// Purpose: Small word buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two, two or more.
// Notes: A flush empties the buffer at once.
`timescale 1ns/1ps
module sl_fifo2 import sl_pkg::*; #(
  parameter int W     = WORD_W,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sl_fifo2: DEPTH must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } sl_fifo_st_t;

  sl_fifo_st_t s_r;
  sl_fifo_st_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s_r.cnt != DEPTH[AW:0]);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // sl_fifo2

// file: hw/sl_pkg.sv
// Purpose: Shared types and constants of the serial line control and status core.
// Assumes: Word bit 0 is the most significant bit of every 16-bit word.
// Notes: Control words arrive as one command plus a 16-bit data word.
package sl_pkg;

  localparam int WORD_W  = 16;
  localparam int CHAR_W  = 8;
  localparam int SLOTS   = 4;
  localparam int MSTAT_W = 6;
  localparam int MIRQ_W  = 4;

  // Indices of the synchronised pin vector.
  localparam int PIN_W   = 9;
  localparam int PIN_RXC = 8;
  localparam int PIN_TXC = 7;
  localparam int PIN_RXD = 6;

  // Field that picks the match slot inside a match word.
  localparam int SLOT_HI = 13;
  localparam int SLOT_LO = 12;

  // Interrupt source indices.
  localparam int SRC_SET  = 0;
  localparam int SRC_XFER = 1;
  localparam int SRC_PERR = 2;
  localparam int SRC_OVR  = 3;
  localparam int SRC_BRK  = 4;
  localparam int SRC_RX   = 5;
  localparam int SRC_TX   = 6;
  localparam int SRC_MTCH = 7;
  localparam int SRC_STAT = 8;
  localparam int SRC_W    = 9;

  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic       TX_MARK  = 1'b1;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [9:0] {
    CMD_LINE     = 10'h001,
    CMD_MATCH    = 10'h002,
    CMD_INTC     = 10'h004,
    CMD_CLR_RX   = 10'h008,
    CMD_IO_RESET = 10'h010,
    CMD_SET_MASK = 10'h020,
    CMD_CLR_MASK = 10'h040,
    CMD_SET_INT  = 10'h080,
    CMD_JUMP     = 10'h100,
    CMD_XFER_ERR = 10'h200
  } sl_cmd_t;

  typedef enum logic [3:0] {
    RX_HUNT = 4'h1,
    RX_WAIT = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } sl_rx_st_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } sl_tx_st_t;

  typedef struct packed {
    sl_cmd_t            sel;
    logic [WORD_W-1:0] data;
  } sl_cmd_req_t;

  typedef struct packed {
    logic async_mode;
    logic rx_pack;
    logic tx_unpack;
    logic par_en;
    logic par_odd;
  } sl_fmt_t;

  typedef struct packed {
    logic [3:0] unused;
    logic       blind;
    logic       tx_dis;
    logic       tx_ie;
    logic       rx_ie;
    logic [3:0] st_ie;
    logic [3:0] ctl_out;
  } sl_line_t;

  typedef struct packed {
    logic [3:0]        unused;
    logic              jump;
    logic              dev_end;
    logic              intr;
    logic              no_sr;
    logic [CHAR_W-1:0] chr;
  } sl_match_t;

  typedef struct packed {
    logic [3:0] unused;
    logic       en;
    logic       clr;
    logic [9:0] rsv;
  } sl_intc_t;

  typedef struct packed {
    logic               prog_ok;
    logic               rw_ok;
    logic               int_pend;
    logic               read_ok;
    logic               write_ok;
    logic               byte_f;
    logic               perr_ovr;
    logic               xfer_err;
    logic               brk;
    logic               assoc;
    logic [MSTAT_W-1:0] mstat;
  } sl_status_t;

endpackage

// file: sim/sl_ctrl_status_tb.sv
// Purpose: Self-checking bench of the control and status core.
// Assumes: Synchronous mode, unpacked receive words.
// Notes: Each scenario is one task.
`timescale 1ns/1ps
module sl_ctrl_status_tb import sl_pkg::*;;
  logic               sys_clk, rst_n, cmd_valid, io_program_active, read_order_active;
  logic               irq, device_end, jump_cond, service_request, rd_ready, wr_valid;
  logic               wr_ready, rx_clk, tx_clk, rx_data, tx_data, hit, space_seen, de_seen;
  sl_cmd_req_t        cmd;
  sl_fmt_t            fmt;
  sl_status_t         status_word;
  logic [WORD_W-1:0]  rd_data, wr_data;
  logic [MSTAT_W-1:0] modem_status_inputs;
  logic [3:0]         modem_ctl;
  logic [7:0]         want;
  int                 miscompares, checks, cycles;

  sl_ctrl_status sl_ctrl_status_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .fmt(fmt), .io_program_active(io_program_active),
    .read_order_active(read_order_active), .status_word(status_word), .irq(irq),
    .device_end(device_end), .jump_cond(jump_cond), .service_request(service_request),
    .rd_ready(rd_ready), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rx_clk(rx_clk), .tx_clk(tx_clk), .rx_data(rx_data),
    .modem_status_inputs(modem_status_inputs), .tx_data(tx_data), .modem_ctl(modem_ctl));
  sl_modem sl_modem_inst (.rx_clk(rx_clk), .rx_data(rx_data), .tx_clk(tx_clk),
    .tx_data(tx_data), .want(want), .hit(hit), .space_seen(space_seen));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (device_end === 1'b1) begin
      de_seen <= 1'b1;
    end
    if (cycles == 20000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmdw(input sl_cmd_t sel, input logic [WORD_W-1:0] d);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= '{sel, d};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic take(input logic [WORD_W-1:0] exp);
    for (int i = 0; i < 400 && service_request !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(rd_data, exp);
    @(posedge sys_clk);
    rd_ready <= 1'b1;
    @(posedge sys_clk);
    rd_ready <= 1'b0;
    #1;
  endtask

  task automatic t_basic;
    chk(status_word, 16'hCC00);
    cmdw(CMD_LINE, 16'h000A);
    chk(16'(modem_ctl), 16'h000A);
    cmdw(CMD_INTC, 16'h0800);
    cmdw(CMD_SET_INT, 16'h0000);
    chk(16'({status_word.int_pend, irq}), 16'h0003);
    cmdw(CMD_INTC, 16'h0C00);
    chk(16'({status_word.int_pend, irq}), 16'h0000);
    cmdw(CMD_CLR_MASK, 16'h0000);
    cmdw(CMD_XFER_ERR, 16'h0000);
    chk(16'({status_word.xfer_err, status_word.int_pend, irq}), 16'h0006);
    cmdw(CMD_SET_MASK, 16'h0000);
    chk(16'(irq), 16'h0001);
  endtask

  task automatic t_mstat;
    cmdw(CMD_LINE, 16'h008A);
    cmdw(CMD_INTC, 16'h0C00);
    modem_status_inputs <= 6'h01;
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'({status_word.mstat, irq}), 16'h0041);
    cmdw(CMD_INTC, 16'h0C00);
    modem_status_inputs <= 6'h03;
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'({status_word.mstat, irq}), 16'h0060);
  endtask

  task automatic t_rx;
    cmdw(CMD_LINE, 16'h010A);
    cmdw(CMD_CLR_RX, 16'h0000);
    cmdw(CMD_MATCH, 16'h0D16);
    de_seen = 1'b0;
    sl_modem_inst.send(8'h16);
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'({jump_cond, de_seen, service_request, status_word.assoc}), 16'h000D);
    sl_modem_inst.send(8'h41);
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'({irq, status_word.read_ok}), 16'h0003);
    take(16'h0041);
    cmdw(CMD_JUMP, 16'h0000);
    chk(16'(jump_cond), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      sl_modem_inst.send(8'h42 + 8'(i));
    end
    #100;
    chk(16'(status_word.perr_ovr), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      take(16'h0042 + 16'(i));
    end
    cmdw(CMD_LINE, 16'h080A);
    sl_modem_inst.send(8'h46);
    repeat (10) @(posedge sys_clk);
    #1;
    chk(16'(service_request), 16'h0000);
  endtask

  task automatic t_tx;
    want = 8'h5A;
    cmdw(CMD_LINE, 16'h020A);
    for (int k = 0; k < 2; k++) begin
      sl_modem_inst.clear;
      cmdw(CMD_INTC, 16'h0C00);
      @(posedge sys_clk);
      wr_valid <= 1'b1;
      wr_data <= 16'h005A;
      @(posedge sys_clk);
      wr_valid <= 1'b0;
      #1;
      chk(16'({wr_ready, status_word.write_ok}), 16'h0000);
      sl_modem_inst.tx_run(24);
      chk(16'({hit, space_seen, irq}), k ? 16'h0001 : 16'h0007);
      cmdw(CMD_LINE, 16'h060A);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '{CMD_LINE, 16'h0000};
    fmt = '0;
    io_program_active = 1'b0;
    read_order_active = 1'b1;
    rd_ready = 1'b0;
    wr_valid = 1'b0;
    wr_data = 16'h0000;
    modem_status_inputs = 6'h00;
    want = 8'h00;
    de_seen = 1'b0;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_basic;
    t_mstat;
    t_rx;
    t_tx;
    close_out;
  end
endmodule // sl_ctrl_status_tb

// file: sim/sl_modem.sv
// Purpose: Behavioural modem on the far side of the serial line.
// Assumes: The receive bit clock runs only inside frames; both bit clocks run at 80 ns per bit.
// Notes: Receive bits change half a period before each rising edge.
`timescale 1ns/1ps
module sl_modem import sl_pkg::*; (
  // Line toward the controller
  output logic              rx_clk,
  output logic              rx_data,
  output logic              tx_clk,
  // Line from the controller
  input  wire logic         tx_data,
  input  wire logic [7:0]   want,
  output logic              hit,
  output logic              space_seen
);
  logic [CHAR_W-1:0] sh;

  initial begin
    rx_clk = 1'b0;
    rx_data = 1'b1;
    tx_clk = 1'b0;
    sh = 8'hFF;
    hit = 1'b0;
    space_seen = 1'b0;
  end

  // Sends one character least significant bit first.
  task automatic send(input logic [CHAR_W-1:0] c);
    #3;
    for (int i = 0; i < CHAR_W; i++) begin
      rx_data = c[i];
      #40 rx_clk = 1'b1;
      #40 rx_clk = 1'b0;
    end
    // The released line must not keep showing the last bit.
    rx_data = ~c[CHAR_W-1];
  endtask

  task automatic tx_run(input int n);
    for (int i = 0; i < n; i++) begin
      #40 tx_clk = 1'b1;
      #40 tx_clk = 1'b0;
    end
  endtask

  task automatic clear;
    hit = 1'b0;
    space_seen = 1'b0;
  endtask

  always @(posedge tx_clk) begin
    sh = {tx_data, sh[CHAR_W-1:1]};
    if (sh === want) begin
      hit = 1'b1;
    end
    if (tx_data === 1'b0) begin
      space_seen = 1'b1;
    end
  end
endmodule // sl_modem
